// >>> wake_ctrl_pkg.sv
package wake_ctrl_pkg;

  // --------------------------------------------------------------------
  // register map (printed offsets are indexes, byte address is 4x)
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h17;
  localparam logic [ADDR_W-1:0] IDX_PAT_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] IDX_PAT_HIGH = 8'h19;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h5c;
  localparam logic [ADDR_W-1:0] ADDR_PAT_LOW = 8'h60;
  localparam logic [ADDR_W-1:0] ADDR_PAT_HIGH = 8'h64;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'hc0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'hc4;

  // --------------------------------------------------------------------
  // control register fields and reset values
  // --------------------------------------------------------------------
  localparam int unsigned POS_PAR_WAKE = 6;
  localparam int unsigned POS_UNIT_SEL = 5;
  localparam int unsigned POS_LEVEL_SEL = 4;
  localparam int unsigned POS_PAR_LEVEL = 3;
  localparam int unsigned POS_CRIT_HI = 2;
  localparam logic [6:0] CONTROL_RESET = 7'h04;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // interrupt status bits
  localparam int unsigned IRQ_IMMEDIATE = 0;
  localparam int unsigned IRQ_BAD_CRIT = 1;
  localparam int unsigned IRQ_SHORT_COUNT = 2;
  localparam int unsigned IRQ_W = 3;

  // external processing codes
  localparam logic [1:0] EXT_SYNC_ONLY = 2'h1;
  localparam logic [1:0] EXT_RSSI_ONLY = 2'h2;

  // count limits
  localparam int unsigned COUNT_W = 7;
  localparam logic [6:0] PAT_MIN_COUNT = 7'h11;
  localparam logic [6:0] COUNT_ZERO = 7'h00;

  // --------------------------------------------------------------------
  // wake criterion codes
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    CRIT_PATTERN = 3'h0,
    CRIT_RANDOM = 3'h1,
    CRIT_EQUAL = 3'h2,
    CRIT_SYNC = 3'h3,
    CRIT_RSSI = 3'h4,
    CRIT_SIGREC = 3'h5,
    CRIT_UNUSED6 = 3'h6,
    CRIT_UNUSED7 = 3'h7
  } crit_e;

  // effective configuration handed to the detectors
  typedef struct packed {
    logic [2:0] criterion;
    logic crit_valid;
    logic data_crit;
    logic level_crit;
    logic par_level_en;
    logic extra_level_sigrec;
    logic par_wake_en;
    logic unit_bits;
    logic count_in_chips;
    logic count_used;
    logic pattern_count_ok;
    logic [15:0] pattern;
  } wake_cfg_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage : wake_ctrl_pkg

// >>> wake_criterion_control.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// [RQ1] control bit 6 turns parallel wake-up on; reset off
// [RQ2] software enables parallel wake only when both configurations share modulation
// [RQ3] control bit 5 picks pattern unit: 0 chips, 1 bits; reset chips
// [RQ4] control bit 4 picks extra level criterion: 0 strength, 1 recognition
// [RQ5] external processing 10 forces signal strength as extra level criterion
// [RQ6] control bit 3 adds parallel level criterion to a data criterion
// [RQ7] parallel level option is ultrafast fall-back, same in constant on-off
// [RQ8] criterion codes: 0-3 data, 4-5 level, 6-7 unused
// [RQ9] external processing 01 maps codes 0,1,2 to symbol sync
// [RQ10] symbol sync criterion ignores the wake count setting
// [RQ11] external processing 10 forces signal strength criterion; reset code 4
// [RQ12] low pattern byte gives pattern positions 7..0
// [RQ13] high pattern byte gives positions 15..8; both reset zero
// [RQ14] pattern mode needs count of at least 17, zero never wakes
// [RQ15] random or equal bits with zero count wake at symbol sync
// [RQ16] count is in chips only in pattern chip mode, else bits
// [RQ17] bit 7 writes ignored; unused criterion codes never wake
// [RQ18] field changes apply at next evaluation with no commit step
module wake_criterion_control
  import wake_ctrl_pkg::*;
(
  input wire logic i_clk, // 40 MHz system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_clk_en, // freezes all state while low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb direction, 1 write
  input wire logic [wake_ctrl_pkg::ADDR_W-1:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped address
  input wire logic [1:0] i_ext_proc, // channel external processing select
  input wire logic [6:0] i_count_limit, // wake count limit setting
  input wire logic i_sym_sync, // pulse: symbol sync found
  output wake_ctrl_pkg::wake_cfg_s o_cfg, // effective wake configuration
  output logic o_immediate_wake, // pulse: zero-count data wake
  output logic o_irq // level interrupt
);
  import wake_ctrl_pkg::*;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  apb_req_s req;
  logic [6:0] control_q;
  logic [7:0] pat_low_q;
  logic [7:0] pat_high_q;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] status_d;
  logic [IRQ_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_mux;
  logic pslverr_q;
  wake_cfg_s cfg_q;
  wake_cfg_s cfg_d;
  logic immediate_q;

  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                 paddr: i_paddr, pwdata: i_pwdata};

  wire setup_rd = req.psel & ~req.penable & ~req.pwrite;
  wire setup = req.psel & ~req.penable;
  wire access_wr = req.psel & req.penable & req.pwrite;
  wire hit_ctrl = (req.paddr == ADDR_CONTROL);
  wire hit_low = (req.paddr == ADDR_PAT_LOW);
  wire hit_high = (req.paddr == ADDR_PAT_HIGH);
  wire hit_stat = (req.paddr == ADDR_IRQ_STATUS);
  wire hit_mask = (req.paddr == ADDR_IRQ_MASK);
  wire hit_any = hit_ctrl | hit_low | hit_high | hit_stat | hit_mask;
  wire wr_ctrl = access_wr & hit_ctrl;
  wire wr_low = access_wr & hit_low;
  wire wr_high = access_wr & hit_high;
  wire wr_stat = access_wr & hit_stat;
  wire wr_mask = access_wr & hit_mask;

  assign rdata_mux = hit_ctrl ? {25'h0, control_q} :
                     hit_low ? {24'h0, pat_low_q} :
                     hit_high ? {24'h0, pat_high_q} :
                     hit_stat ? {29'h0, status_q} :
                     hit_mask ? {29'h0, mask_q} : 32'h0;

  // zero wait states: read data and error settle during setup
  assign o_pready = 1'b1;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q & req.psel & req.penable;

  // ------------------------------------------------------------------
  // criterion resolution
  // ------------------------------------------------------------------
  wire [2:0] crit_raw = control_q[POS_CRIT_HI:0];
  wire ext_rssi = (i_ext_proc == EXT_RSSI_ONLY);
  wire ext_sync = (i_ext_proc == EXT_SYNC_ONLY);
  wire raw_low_data = (crit_raw == CRIT_PATTERN) |
                      (crit_raw == CRIT_RANDOM) |
                      (crit_raw == CRIT_EQUAL);
  wire [2:0] crit_eff = ext_rssi ? CRIT_RSSI : // see [RQ11]
                        (ext_sync & raw_low_data) ? CRIT_SYNC : // see [RQ9]
                        crit_raw;
  wire is_data = (crit_eff == CRIT_PATTERN) | (crit_eff == CRIT_RANDOM) |
                 (crit_eff == CRIT_EQUAL) | (crit_eff == CRIT_SYNC); // see [RQ8]
  wire is_level = (crit_eff == CRIT_RSSI) | (crit_eff == CRIT_SIGREC);
  wire is_pattern = (crit_eff == CRIT_PATTERN);
  wire zero_count_crit = (crit_eff == CRIT_RANDOM) |
                         (crit_eff == CRIT_EQUAL);
  wire count_zero = (i_count_limit == COUNT_ZERO);
  wire pat_count_ok = (i_count_limit >= PAT_MIN_COUNT); // see [RQ14]

  // parallel level is the ultrafast fall-back in every operating mode
  wire par_level = control_q[POS_PAR_LEVEL] & is_data; // see [RQ6] [RQ7]
  wire level_sel = ext_rssi ? 1'b0 : control_q[POS_LEVEL_SEL]; // see [RQ4] [RQ5]

  always_comb begin
    cfg_d.criterion = crit_eff;
    cfg_d.crit_valid = is_data | is_level; // see [RQ17]
    cfg_d.data_crit = is_data;
    cfg_d.level_crit = is_level;
    cfg_d.par_level_en = par_level;
    cfg_d.extra_level_sigrec = level_sel;
    cfg_d.par_wake_en = control_q[POS_PAR_WAKE]; // see [RQ1]
    cfg_d.unit_bits = control_q[POS_UNIT_SEL]; // see [RQ3]
    cfg_d.count_in_chips = is_pattern & ~control_q[POS_UNIT_SEL]; // see [RQ16]
    cfg_d.count_used = is_data & (crit_eff != CRIT_SYNC); // see [RQ10]
    cfg_d.pattern_count_ok = is_pattern & pat_count_ok; // see [RQ14]
    cfg_d.pattern = {pat_high_q, pat_low_q}; // see [RQ12] [RQ13]
  end

  wire immediate_ev = i_sym_sync & zero_count_crit & count_zero; // see [RQ15]
  wire bad_crit_ev = wr_ctrl &
                     (i_pwdata[POS_CRIT_HI:0] == CRIT_UNUSED6 |
                      i_pwdata[POS_CRIT_HI:0] == CRIT_UNUSED7);
  wire short_ev = i_sym_sync & is_pattern & ~pat_count_ok;

  // ------------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ------------------------------------------------------------------
  wire [IRQ_W-1:0] events = {short_ev, bad_crit_ev, immediate_ev};
  wire [IRQ_W-1:0] clr = wr_stat ? i_pwdata[IRQ_W-1:0] : '0;
  assign status_d = (status_q & ~clr) | events;
  assign o_irq = |(status_q & mask_q);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      control_q <= CONTROL_RESET;
      pat_low_q <= PATTERN_RESET;
      pat_high_q <= PATTERN_RESET;
    end else if (i_clk_en) begin
      // bit 7 is not stored, writes to it vanish
      if (wr_ctrl) control_q <= i_pwdata[6:0]; // see [RQ17] [RQ18]
      if (wr_low) pat_low_q <= i_pwdata[7:0]; // see [RQ12]
      if (wr_high) pat_high_q <= i_pwdata[7:0]; // see [RQ13]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (i_clk_en) begin
      status_q <= status_d;
      if (wr_mask) mask_q <= i_pwdata[IRQ_W-1:0];
      if (setup_rd) prdata_q <= rdata_mux;
      if (setup) pslverr_q <= ~hit_any;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_q <= '0;
      immediate_q <= 1'b0;
    end else if (i_clk_en) begin
      cfg_q <= cfg_d; // see [RQ18]
      immediate_q <= immediate_ev;
    end
  end

  assign o_cfg = cfg_q;
  assign o_immediate_wake = immediate_q;

endmodule : wake_criterion_control

// >>> wake_ctrl_pkg_unused_guard.sv
`timescale 1ns/10ps

// >>> wake_criterion_control_asserts.sv
`timescale 1ns/10ps
module wake_criterion_control_asserts
  import wake_ctrl_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_clk_en, // enable
  input wire logic [1:0] i_ext_proc, // external processing
  input wire logic [6:0] i_count_limit, // count limit
  input wire logic i_sym_sync, // sync pulse
  input wire logic o_immediate_wake, // zero-count wake
  input wire wake_ctrl_pkg::wake_cfg_s o_cfg // effective config
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence ext_rssi_s;
    i_clk_en && i_ext_proc == 2'h2;
  endsequence
  sequence ext_sync_s;
    i_clk_en && i_ext_proc == 2'h1;
  endsequence
  a_ext_forces_rssi: assert property (
    ext_rssi_s |=> o_cfg.criterion == 3'h4) else $error("no forced code");
  a_ext_forces_level: assert property (
    ext_rssi_s |=> !o_cfg.extra_level_sigrec) else $error("level not rssi");
  a_ext_maps_sync: assert property (
    ext_sync_s |=> o_cfg.criterion > 3'h2) else $error("codes not mapped");
  a_chip_unit_only: assert property (
    o_cfg.count_in_chips |-> o_cfg.criterion == 3'h0 && !o_cfg.unit_bits)
    else $error("count unit wrong");
  a_sync_no_count: assert property (
    o_cfg.criterion == 3'h3 |-> !o_cfg.count_used) else $error("count used");
  a_par_level_data: assert property (
    o_cfg.par_level_en |-> o_cfg.data_crit) else $error("par level bad");
  a_unused_invalid: assert property (
    o_cfg.criterion[2:1] == 2'h3 |-> !o_cfg.crit_valid)
    else $error("unused code valid");
  a_pattern_short: assert property (
    i_clk_en && i_count_limit < 7'h11 |=> !o_cfg.pattern_count_ok)
    else $error("short count accepted");
  a_imm_cause: assert property (
    o_immediate_wake && $past(i_clk_en) |->
      $past(i_sym_sync) && $past(i_count_limit) == 7'h0)
    else $error("wake without cause");
endmodule : wake_criterion_control_asserts

bind wake_criterion_control wake_criterion_control_asserts chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_ext_proc(i_ext_proc), .i_count_limit(i_count_limit),
  .i_sym_sync(i_sym_sync), .o_immediate_wake(o_immediate_wake),
  .o_cfg(o_cfg));

// >>> tb_wake_criterion_control.sv
`timescale 1ns/10ps
module tb_wake_criterion_control;
  import wake_ctrl_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_clk_en = 1, i_sym_sync = 0;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic o_pready, o_pslverr, o_immediate_wake, o_irq;
  logic [1:0] i_ext_proc = '0;
  logic [6:0] i_count_limit = '0;
  wake_cfg_s o_cfg;
  int fail_count = 0, cmp_count = 0;
  wake_criterion_control dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_proc(i_ext_proc), .i_count_limit(i_count_limit),
    .i_sym_sync(i_sym_sync), .o_cfg(o_cfg),
    .o_immediate_wake(o_immediate_wake), .o_irq(o_irq));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------
  // bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // wait for ready; only the watchdog ends a hung wait
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, 1'b0);
  endtask : rd
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(ADDR_CONTROL, 32'h4);
    rd(ADDR_PAT_HIGH, 32'h0);
    chk(o_cfg.criterion, 3'h4);
    // unmapped address reads zero with error
    apb(1'b0, 8'hf0, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fields;
    // both configurations share one modulation here
    wr(ADDR_CONTROL, 32'hfb);
    rd(ADDR_CONTROL, 32'h7b);
    chk({o_cfg.par_wake_en, o_cfg.unit_bits, o_cfg.extra_level_sigrec,
         o_cfg.par_level_en, o_cfg.count_used}, 5'h1e);
    i_ext_proc <= 2'h2;
    wr(ADDR_PAT_LOW, 32'ha5);
    chk({o_cfg.criterion, o_cfg.extra_level_sigrec}, 4'h8);
    i_ext_proc <= 2'h1;
    wr(ADDR_CONTROL, 32'h0);
    chk(o_cfg.criterion, 3'h3);
    i_ext_proc <= 2'h0;
    i_count_limit <= 7'h10;
    wr(ADDR_PAT_HIGH, 32'h3c);
    chk(o_cfg.pattern, 16'h3ca5);
    chk({o_cfg.count_in_chips, o_cfg.pattern_count_ok}, 2'h2);
    i_count_limit <= 7'h11;
    wr(ADDR_CONTROL, 32'h20);
    chk({o_cfg.count_in_chips, o_cfg.pattern_count_ok}, 2'h1);
    $display("field test done");
  endtask : t_fields
  task automatic t_irq;
    i_count_limit <= 7'h0;
    wr(ADDR_CONTROL, 32'h1);
    i_sym_sync <= 1'b1;
    @(posedge i_clk);
    i_sym_sync <= 1'b0;
    @(posedge i_clk);
    chk({o_immediate_wake, o_irq}, 2'h2);
    wr(ADDR_IRQ_MASK, 32'h7);
    chk(o_irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    chk(o_irq, 1'b0);
    wr(ADDR_CONTROL, 32'h6);
    chk({o_cfg.crit_valid, o_irq}, 2'h1);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_restart;
    // a write while the clock enable is low is lost
    i_clk_en <= 1'b0;
    wr(ADDR_PAT_LOW, 32'h55);
    i_clk_en <= 1'b1;
    rd(ADDR_PAT_LOW, 32'ha5);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(ADDR_CONTROL, 32'h4);
    rd(ADDR_PAT_LOW, 32'h0);
    chk(o_irq, 1'b0);
    $display("restart test done");
  endtask : t_restart
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_irq();
    t_restart();
    print_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_wake_criterion_control
